/* shared/pst_pkg.sv */
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package pst_pkg;
  localparam int PST_CNT_W = 16;
  localparam int PST_DT_W = 8;
  localparam int PST_ADDR_W = 4;
  localparam int PST_DATA_W = 32;
  localparam int PST_PHASES = 3;
  // register word indices, byte offset is four times the index
  localparam logic [PST_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [PST_ADDR_W-1:0] REG_PERIOD = 4'h1;
  localparam logic [PST_ADDR_W-1:0] REG_CMP0 = 4'h2;
  localparam logic [PST_ADDR_W-1:0] REG_CMP1 = 4'h3;
  localparam logic [PST_ADDR_W-1:0] REG_CMP2 = 4'h4;
  localparam logic [PST_ADDR_W-1:0] REG_DEAD = 4'h5;
  localparam logic [PST_ADDR_W-1:0] REG_TDT_DLY = 4'h6;
  localparam logic [PST_ADDR_W-1:0] REG_SST_DLY = 4'h7;
  localparam logic [PST_ADDR_W-1:0] REG_MIN_SENSE = 4'h8;
  localparam logic [PST_ADDR_W-1:0] REG_STATUS = 4'h9;
  localparam logic [PST_ADDR_W-1:0] REG_SST_CNT = 4'ha;
  // control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_OUT_EN = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_CLK_SEL = 4;
  localparam int CTRL_CHAN_LO = 5;
  localparam int CTRL_TDT_SRC = 7;
  localparam int CTRL_VSUP = 8;
  localparam int CTRL_W = 9;
  // status field positions
  localparam int STAT_DIR = 16;
  localparam int STAT_FAULT = 17;
  localparam int STAT_FAULT_RAW = 18;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [PST_CNT_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [PST_CNT_W-1:0] CMP_RST = 16'h0000;
  localparam logic [PST_DT_W-1:0] DEAD_RST = 8'h00;
  localparam logic [PST_CNT_W-1:0] DLY_RST = 16'h0000;
  localparam logic [PST_CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [PST_CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [PST_DT_W-1:0] DT_ZERO = 8'h00;
  localparam logic [PST_DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    SST_TIMER,
    SST_COUNTER,
    SST_PWM_SYNC,
    SST_GATED
  } pst_sst_mode_t;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } pst_dir_t;

  typedef enum logic {
    CH_CURRENT,
    CH_SUPPLY
  } pst_chan_t;
endpackage

/* hdl/pst_dead_time.sv */
`timescale 1ns/1ps
// one half-bridge: complementary gates with a dead gap on every switch-over
module pst_dead_time (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic pwm_in,
  input wire logic [pst_pkg::PST_DT_W-1:0] dead,
  output logic gate_hi,
  output logic gate_lo
);
  import pst_pkg::*;

  logic last_reg;
  logic [PST_DT_W-1:0] gap_reg;

  // ---------------------------------------------------------------
  // gap counter
  // ---------------------------------------------------------------
  // any change of pwm restarts the gap; both gates stay off meanwhile
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_reg <= 1'b0;
      gap_reg <= DT_ZERO;
    end else begin
      last_reg <= pwm_in;
      if (pwm_in != last_reg) begin
        gap_reg <= dead;
      end else if (gap_reg != DT_ZERO) begin
        gap_reg <= gap_reg - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // gate outputs
  // ---------------------------------------------------------------
  // registered, so a disable drops both gates one edge later; a bridge fault takes four edges via the synchroniser and fault_reg
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
    end else if (!enable || pwm_in != last_reg || gap_reg != DT_ZERO) begin
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
    end else begin
      gate_hi <= last_reg;
      gate_lo <= ~last_reg;
    end
  end
endmodule

/* hdl/pst_top.sv */
`timescale 1ns/1ps
module pst_top (
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [pst_pkg::PST_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pst_pkg::PST_DATA_W-1:0] avs_writedata,
  output logic [pst_pkg::PST_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // bridge driver
  output logic [pst_pkg::PST_PHASES-1:0] gate_hi,
  output logic [pst_pkg::PST_PHASES-1:0] gate_lo,
  input wire logic bridge_fault,
  // sync sample timer inputs
  input wire logic low_power_clock,
  input wire logic sst_count_in,
  input wire logic sst_gate_in,
  // current converter
  output logic conv_start,
  output logic conv_chan,
  output logic first_sample_event,
  output logic second_sample_event,
  input wire logic conv_done,
  output logic conv_irq,
  // main timer events
  output logic period_match_evt,
  output logic one_match_evt
);
  import pst_pkg::*;

  function automatic logic [PST_CNT_W-1:0] max_cnt(
    input logic [PST_CNT_W-1:0] a,
    input logic [PST_CNT_W-1:0] b
  );
    max_cnt = (a > b) ? a : b;
  endfunction

  logic [CTRL_W-1:0] ctrl_reg;
  logic [PST_CNT_W-1:0] period_reg, tdt_dly_reg, sst_dly_reg, min_sense_reg;
  logic [PST_CNT_W-1:0] cmp_reg [PST_PHASES];
  logic [PST_CNT_W-1:0] cmp_act_reg [PST_PHASES];
  logic [PST_CNT_W-1:0] period_act_reg;
  logic [PST_DT_W-1:0] dead_reg;
  logic fault_reg, ack_reg;
  logic [PST_CNT_W-1:0] cnt_reg, tdt_cnt_reg, sst_cnt_reg;
  pst_dir_t dir_reg;
  logic tdt_run_reg, sst_run_reg;
  logic [2:0] fault_sync, lp_sync, ci_sync, gt_sync, done_sync;
  logic run, out_en, wr_en, rd_en, zero_match, period_match, cmp_match;
  logic lp_tick, sst_tick, fall_in, vsup_pend_reg;
  logic [PST_PHASES-1:0] pwm_raw;
  logic [PST_CNT_W-1:0] tdt_lim, sst_lim;
  pst_sst_mode_t sst_mode;

  assign run = ctrl_reg[CTRL_RUN];
  assign out_en = ctrl_reg[CTRL_OUT_EN] & ~fault_reg;
  assign sst_mode = pst_sst_mode_t'(ctrl_reg[CTRL_MODE_LO +: 2]);

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle per access
  // ---------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_en = avs_write & ack_reg;
  assign rd_en = avs_read & ~ack_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // read mux, captured during the wait cycle; unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_readdata <= RD_ZERO;
    end else if (rd_en) begin
      avs_readdata <= RD_ZERO;
      unique case (avs_address)
        REG_CTRL: avs_readdata[CTRL_W-1:0] <= ctrl_reg;
        REG_PERIOD: avs_readdata[PST_CNT_W-1:0] <= period_reg;
        REG_CMP0: avs_readdata[PST_CNT_W-1:0] <= cmp_reg[0];
        REG_CMP1: avs_readdata[PST_CNT_W-1:0] <= cmp_reg[1];
        REG_CMP2: avs_readdata[PST_CNT_W-1:0] <= cmp_reg[2];
        REG_DEAD: avs_readdata[PST_DT_W-1:0] <= dead_reg;
        REG_TDT_DLY: avs_readdata[PST_CNT_W-1:0] <= tdt_dly_reg;
        REG_SST_DLY: avs_readdata[PST_CNT_W-1:0] <= sst_dly_reg;
        REG_MIN_SENSE: avs_readdata[PST_CNT_W-1:0] <= min_sense_reg;
        REG_STATUS: begin
          avs_readdata[PST_CNT_W-1:0] <= cnt_reg;
          avs_readdata[STAT_DIR] <= (dir_reg == DIR_DOWN);
          avs_readdata[STAT_FAULT] <= fault_reg;
          avs_readdata[STAT_FAULT_RAW] <= fault_sync[1];
        end
        REG_SST_CNT: avs_readdata[PST_CNT_W-1:0] <= sst_cnt_reg;
        default: avs_readdata <= RD_ZERO;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      period_reg <= PERIOD_RST;
      cmp_reg <= '{default: CMP_RST};
      dead_reg <= DEAD_RST;
      tdt_dly_reg <= DLY_RST;
      sst_dly_reg <= DLY_RST;
      min_sense_reg <= DLY_RST;
    end else if (wr_en) begin
      unique case (avs_address)
        REG_CTRL: ctrl_reg <= avs_writedata[CTRL_W-1:0];
        REG_PERIOD: period_reg <= avs_writedata[PST_CNT_W-1:0];
        REG_CMP0: cmp_reg[0] <= avs_writedata[PST_CNT_W-1:0];
        REG_CMP1: cmp_reg[1] <= avs_writedata[PST_CNT_W-1:0];
        REG_CMP2: cmp_reg[2] <= avs_writedata[PST_CNT_W-1:0];
        REG_DEAD: dead_reg <= avs_writedata[PST_DT_W-1:0];
        REG_TDT_DLY: tdt_dly_reg <= avs_writedata[PST_CNT_W-1:0];
        REG_SST_DLY: sst_dly_reg <= avs_writedata[PST_CNT_W-1:0];
        REG_MIN_SENSE: min_sense_reg <= avs_writedata[PST_CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // stage 0 feeds only stage 1; edge logic looks at stages 1 and 2
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_sync <= 3'h0;
      lp_sync <= 3'h0;
      ci_sync <= 3'h0;
      gt_sync <= 3'h0;
      done_sync <= 3'h0;
    end else begin
      fault_sync <= {fault_sync[1:0], bridge_fault};
      lp_sync <= {lp_sync[1:0], low_power_clock};
      ci_sync <= {ci_sync[1:0], sst_count_in};
      gt_sync <= {gt_sync[1:0], sst_gate_in};
      done_sync <= {done_sync[1:0], conv_done};
    end
  end

  // sticky fault, write one to clear; a live fault wins over the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_reg <= 1'b0;
    end else if (fault_sync[1]) begin
      fault_reg <= 1'b1;
    end else if (wr_en && avs_address == REG_STATUS && avs_writedata[STAT_FAULT]) begin
      fault_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // main pwm timer, center aligned
  // ---------------------------------------------------------------
  assign zero_match = run & (cnt_reg == CNT_ZERO);
  // a held timer (period zero) sits at zero and must not flood period events
  assign period_match = run & (dir_reg == DIR_UP) & (period_act_reg != CNT_ZERO)
                      & (cnt_reg == period_act_reg);

  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      cnt_reg <= CNT_ZERO;
      dir_reg <= DIR_UP;
    end else if (period_act_reg == CNT_ZERO) begin
      cnt_reg <= CNT_ZERO;
    end else if (dir_reg == DIR_UP) begin
      if (cnt_reg >= period_act_reg) begin
        dir_reg <= DIR_DOWN;
        cnt_reg <= cnt_reg - 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end else if (cnt_reg == CNT_ZERO) begin
      dir_reg <= DIR_UP;
      cnt_reg <= CNT_ONE;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // shadow transfer at zero match keeps each pwm cycle symmetric
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      period_act_reg <= PERIOD_RST;
      cmp_act_reg <= '{default: CMP_RST};
    end else if (!run || zero_match) begin
      period_act_reg <= period_reg;
      cmp_act_reg <= cmp_reg;
    end
  end

  // phase is on while the count sits at or above its compare value
  always_comb begin
    for (int i = 0; i < PST_PHASES; i++) begin
      pwm_raw[i] = run & (cnt_reg >= cmp_act_reg[i]);
    end
  end

  // timer event pulses for software reading the converted currents
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      period_match_evt <= 1'b0;
      one_match_evt <= 1'b0;
    end else begin
      period_match_evt <= period_match;
      one_match_evt <= run & (dir_reg == DIR_UP) & (cnt_reg == CNT_ONE);
    end
  end

  // ---------------------------------------------------------------
  // half-bridge dead-time stages
  // ---------------------------------------------------------------
  for (genvar g = 0; g < PST_PHASES; g++) begin : g_leg
    pst_dead_time u_dt (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(out_en),
      .pwm_in(pwm_raw[g]),
      .dead(dead_reg),
      .gate_hi(gate_hi[g]),
      .gate_lo(gate_lo[g])
    );
  end

  // ---------------------------------------------------------------
  // trigger delay timer, single shot
  // ---------------------------------------------------------------
  // compare match only counts while falling, i.e. the phase switching off
  assign cmp_match = run & (dir_reg == DIR_DOWN)
                   & (cnt_reg == cmp_act_reg[ctrl_reg[CTRL_CHAN_LO +: 2]]);
  // stretch the delay so the sense window is never shorter than allowed
  assign tdt_lim = max_cnt(tdt_dly_reg, min_sense_reg);

  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      tdt_run_reg <= 1'b0;
      tdt_cnt_reg <= CNT_ZERO;
      second_sample_event <= 1'b0;
    end else begin
      second_sample_event <= 1'b0;
      if (!tdt_run_reg && (ctrl_reg[CTRL_TDT_SRC] ? period_match : cmp_match)) begin
        tdt_run_reg <= 1'b1;
        tdt_cnt_reg <= CNT_ZERO;
      end else if (tdt_run_reg) begin
        if (tdt_cnt_reg >= tdt_lim) begin
          tdt_run_reg <= 1'b0;
          second_sample_event <= 1'b1;
        end else begin
          tdt_cnt_reg <= tdt_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // sync sample timer
  // ---------------------------------------------------------------
  assign lp_tick = lp_sync[1] & ~lp_sync[2];
  assign fall_in = ~ci_sync[1] & ci_sync[2];
  assign sst_tick = ctrl_reg[CTRL_CLK_SEL] ? lp_tick : 1'b1;
  assign sst_lim = max_cnt(sst_dly_reg, min_sense_reg);

  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      sst_cnt_reg <= CNT_ZERO;
      sst_run_reg <= 1'b0;
      first_sample_event <= 1'b0;
    end else begin
      first_sample_event <= 1'b0;
      unique case (sst_mode)
        SST_TIMER: if (sst_tick) sst_cnt_reg <= sst_cnt_reg + 1'b1;
        SST_COUNTER: if (fall_in) sst_cnt_reg <= sst_cnt_reg + 1'b1;
        SST_GATED: if (sst_tick && gt_sync[1]) sst_cnt_reg <= sst_cnt_reg + 1'b1;
        SST_PWM_SYNC: begin
          if (zero_match && !sst_run_reg) begin // zero is the turn into up counting
            sst_run_reg <= 1'b1;
            sst_cnt_reg <= CNT_ZERO;
          end else if (sst_run_reg && sst_tick) begin
            if (sst_cnt_reg >= sst_lim) begin
              sst_run_reg <= 1'b0;
              first_sample_event <= 1'b1;
            end else begin
              sst_cnt_reg <= sst_cnt_reg + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // converter start, channel and done interrupt
  // ---------------------------------------------------------------
  // supply request is served at period match, away from both sample points
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vsup_pend_reg <= 1'b0;
    end else if (ctrl_reg[CTRL_VSUP] && period_match) begin
      vsup_pend_reg <= 1'b1;
    end else if (vsup_pend_reg && !first_sample_event && !second_sample_event) begin
      vsup_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_start <= 1'b0;
      conv_chan <= CH_CURRENT;
    end else if (first_sample_event || second_sample_event) begin
      conv_start <= 1'b1;
      conv_chan <= CH_CURRENT;
    end else if (vsup_pend_reg) begin
      conv_start <= 1'b1;
      conv_chan <= CH_SUPPLY;
    end else begin
      conv_start <= 1'b0;
    end
  end

  // interrupt pulse on each completed conversion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= done_sync[1] & ~done_sync[2];
    end
  end
endmodule

/* verif/pst_far_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// bridge driver and shunt converter stand-in
// ----------------------------------------
module pst_far_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [pst_pkg::PST_PHASES-1:0] gate_hi,
  input wire logic [pst_pkg::PST_PHASES-1:0] gate_lo,
  input wire logic conv_start,
  input wire logic fault_req,
  output logic bridge_fault,
  output logic conv_done
);
  import pst_pkg::*;
  logic [3:0] busy_reg;
  // fixed conversion time; done held three cycles so the synchroniser sees it
  always_ff @(posedge ref_clk) begin
    if (rst)
      busy_reg <= 4'h0;
    else if (conv_start)
      busy_reg <= 4'h9;
    else if (busy_reg != 4'h0)
      busy_reg <= busy_reg - 4'h1;
  end
  assign conv_done = (busy_reg != 4'h0) && (busy_reg < 4'h4);
  // fault on request, and on any shoot-through seen at the gates
  assign bridge_fault = fault_req | (|(gate_hi & gate_lo));
endmodule

/* verif/pst_top_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checks of the pwm and trigger block
// ----------------------------------------
module pst_top_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [pst_pkg::PST_PHASES-1:0] gate_hi,
  input wire logic [pst_pkg::PST_PHASES-1:0] gate_lo,
  input wire logic bridge_fault,
  input wire logic conv_start,
  input wire logic conv_chan,
  input wire logic first_sample_event,
  input wire logic second_sample_event,
  input wire logic conv_done,
  input wire logic conv_irq,
  input wire logic period_match_evt
);
  import pst_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // bus answers after exactly one wait cycle
  property p_bus_wait; ($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait wrong");
  // no leg ever has both transistors on
  property p_no_overlap; (gate_hi & gate_lo) == '0; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
  // a gate only rises after its partner was already off
  property p_dead; ((gate_lo & ~$past(gate_lo) & $past(gate_hi)) |
    (gate_hi & ~$past(gate_hi) & $past(gate_lo))) == '0; endproperty
  a_dead: assert property (p_dead) else $error("no dead gap");
  property p_first_pulse; first_sample_event |=> !first_sample_event; endproperty
  a_first_pulse: assert property (p_first_pulse) else $error("trigger one long");
  property p_first_conv; first_sample_event |=> conv_start && !conv_chan; endproperty
  a_first_conv: assert property (p_first_conv) else $error("trigger one lost");
  property p_second_conv; second_sample_event |=> conv_start && !conv_chan; endproperty
  a_second_conv: assert property (p_second_conv) else $error("trigger two lost");
  // synchroniser plus edge detect, three edges nominal
  property p_irq; $rose(conv_done) |-> ##[2:4] conv_irq; endproperty
  a_irq: assert property (p_irq) else $error("no conversion irq");
  property p_fault_off; bridge_fault [*6] |-> (gate_hi | gate_lo) == '0; endproperty
  a_fault_off: assert property (p_fault_off) else $error("gates on in fault");
  property p_period_pulse; period_match_evt |=> !period_match_evt; endproperty
  a_period_pulse: assert property (p_period_pulse) else $error("period event long");
  c_first: cover property (first_sample_event);
  c_second: cover property (second_sample_event);
  c_irq: cover property (conv_irq);
endmodule
bind pst_top pst_top_chk pst_top_chk_i (.ref_clk(ref_clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .gate_hi(gate_hi),
  .gate_lo(gate_lo), .bridge_fault(bridge_fault), .conv_start(conv_start),
  .conv_chan(conv_chan), .first_sample_event(first_sample_event),
  .second_sample_event(second_sample_event), .conv_done(conv_done), .conv_irq(conv_irq),
  .period_match_evt(period_match_evt));

/* verif/pwm_shunt_sample_trigger_test.sv */
`timescale 1ns/1ps
module pwm_shunt_sample_trigger_test;
  import pst_pkg::*;
  localparam int P = 20;
  localparam int D = 3;
  localparam logic [31:0] CFG = 32'h0000_008b; // run, gates on, pwm sync, delay on period
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [PST_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [PST_DATA_W-1:0] avs_writedata = '0;
  logic [PST_DATA_W-1:0] avs_readdata, rd, base;
  logic avs_waitrequest, bridge_fault, conv_start, conv_chan, conv_done, conv_irq;
  logic first_sample_event, second_sample_event, period_match_evt, one_match_evt;
  logic [PST_PHASES-1:0] gate_hi, gate_lo;
  logic low_power_clock = 1'b0;
  logic sst_count_in = 1'b1;
  logic sst_gate_in = 1'b0;
  logic fault_req = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  // tallies: 0 length, 1 first, 2 second, 3 first at, 4 second at,
  // 5 irq, 6 supply, 7 one match, 8 low gate 0, 9.. high gates
  int m [12];
  pst_top pst_top_i (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gate_hi(gate_hi),
    .gate_lo(gate_lo), .bridge_fault(bridge_fault), .low_power_clock(low_power_clock),
    .sst_count_in(sst_count_in), .sst_gate_in(sst_gate_in), .conv_start(conv_start),
    .conv_chan(conv_chan), .first_sample_event(first_sample_event),
    .second_sample_event(second_sample_event), .conv_done(conv_done), .conv_irq(conv_irq),
    .period_match_evt(period_match_evt), .one_match_evt(one_match_evt));
  pst_far_model pst_far_model_i (.ref_clk(ref_clk), .rst(rst), .gate_hi(gate_hi),
    .gate_lo(gate_lo), .conv_start(conv_start), .fault_req(fault_req),
    .bridge_fault(bridge_fault), .conv_done(conv_done));
  // ----------------------------------------
  // clock and helpers
  // ----------------------------------------
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  // hold the request until waitrequest is sampled low, bounded
  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) begin
        num_errors++;
        report_and_stop();
      end
    end while (avs_waitrequest !== 1'b0);
  endtask
  task automatic bus_write(input logic [PST_ADDR_W-1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic bus_read(input logic [PST_ADDR_W-1:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 0;
    @(posedge ref_clk);
  endtask
  task automatic wait_pm(input bit tally);
    if (tally)
      m = '{default: 0};
    do begin
      @(posedge ref_clk);
      m[0]++;
      if (first_sample_event === 1'b1)
        m[3] = m[0];
      if (second_sample_event === 1'b1)
        m[4] = m[0];
      m[1] += (first_sample_event === 1'b1);
      m[2] += (second_sample_event === 1'b1);
      m[5] += (conv_irq === 1'b1);
      m[6] += (conv_start === 1'b1 && conv_chan === 1'b1);
      m[7] += (one_match_evt === 1'b1);
      m[8] += (gate_lo[0] === 1'b1);
      for (int p = 0; p < PST_PHASES; p++)
        m[9 + p] += (gate_hi[p] === 1'b1);
      if (m[0] > 500) begin
        num_errors++;
        report_and_stop();
      end
    end while (period_match_evt !== 1'b1);
  endtask
  // skip two settling cycles so shadowed values are in force, then tally one
  task automatic measure();
    m = '{default: 0};
    wait_pm(1'b0);
    wait_pm(1'b0);
    wait_pm(1'b1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    bus_read(REG_CTRL, rd);
    chk("ctrl reset", 32'h0, rd);
    bus_read(REG_PERIOD, rd);
    chk("period reset", 32'h0, rd);
    bus_write(4'hf, 32'hffff_ffff);
    bus_read(4'hf, rd);
    chk("unmapped read", 32'h0, rd);
    bus_write(REG_CMP1, 32'h0000_000a);
    bus_read(REG_CMP1, rd);
    chk("cmp1 readback", 32'h0000_000a, rd);
  endtask
  task automatic t_pwm();
    int f0, s0;
    bus_write(REG_PERIOD, P);
    for (int p = 0; p < PST_PHASES; p++)
      bus_write(PST_ADDR_W'(REG_CMP0 + p), 5 * (p + 1));
    bus_write(REG_DEAD, D);
    bus_write(REG_TDT_DLY, 3);
    bus_write(REG_SST_DLY, 4);
    bus_write(REG_CTRL, CFG);
    measure();
    chk("cycle length", 2 * P, m[0]);
    chk("first events", 1, m[1]);
    chk("second events", 1, m[2]);
    chk("one match", 1, m[7]);
    chk("irq count", 2, m[5]);
    chk("low gate 0", 10 - 1 - (D + 1), m[8]);
    for (int p = 0; p < PST_PHASES; p++)
      chk("high gate", 2 * P - 10 * (p + 1) + 1 - (D + 1), m[9 + p]);
    f0 = m[3];
    s0 = m[4];
    bus_write(REG_MIN_SENSE, 8);
    measure();
    chk("first floor", f0 + 4, m[3]);
    chk("second floor", s0 + 5, m[4]);
    bus_write(REG_MIN_SENSE, 0);
    bus_write(REG_CTRL, 32'h0000_002b); // delay started by compare 1 while down
    measure();
    chk("second on compare", s0 + P - 10, m[4]);
    bus_write(REG_CTRL, CFG | 32'h0000_0100);
    measure();
    chk("supply conversions", 1, m[6]);
  endtask
  task automatic t_fault();
    fault_req <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("gates in fault", 0, {gate_hi, gate_lo});
    bus_read(REG_STATUS, rd);
    chk("fault flags", 3, rd[18:17]);
    fault_req <= 1'b0;
    repeat (5) @(posedge ref_clk);
    bus_write(REG_STATUS, 32'h0002_0000);
    bus_read(REG_STATUS, rd);
    chk("fault cleared", 0, rd[18:17]);
    bus_write(REG_CTRL, 32'h0000_0089); // gates disabled
    measure();
    chk("gates disabled", 0, m[9] + m[8]);
  endtask
  // sample timer in counter, low power timer and gated modes, gate closed then open
  task automatic t_sst();
    bus_write(REG_PERIOD, 0);
    bus_write(REG_SST_DLY, 32'h0000_ffff);
    bus_write(REG_CTRL, 32'h0000_0005);
    bus_read(REG_SST_CNT, base);
    repeat (5) begin
      sst_count_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
      sst_count_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    bus_read(REG_SST_CNT, rd);
    chk("falling edges", base + 5, rd);
    bus_write(REG_CTRL, 32'h0000_0011);
    bus_read(REG_SST_CNT, base);
    repeat (4) begin
      low_power_clock <= 1'b1;
      repeat (4) @(posedge ref_clk);
      low_power_clock <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    bus_read(REG_SST_CNT, rd);
    chk("low power ticks", base + 4, rd);
    bus_write(REG_CTRL, 32'h0000_000d);
    bus_read(REG_SST_CNT, base);
    repeat (10) @(posedge ref_clk);
    bus_read(REG_SST_CNT, rd);
    chk("closed gate", base, rd);
    // gate opens after two sync stages, so 10 waited edges give 8 ticks
    base = rd;
    sst_gate_in <= 1'b1;
    repeat (10) @(posedge ref_clk);
    bus_read(REG_SST_CNT, rd);
    chk("open gate", base + 8, rd);
    sst_gate_in <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_pwm();
    t_fault();
    t_sst();
    report_and_stop();
  end
endmodule
